// [src/vfdtc_scan_timing.sv]
`timescale 1ns/100ps
`default_nettype none
module vfdtc_scan_timing
   import vfdtc_pkg::*;
#(
   parameter int OUT_W = 60,
   parameter int LED_W = 17
) (
   input  wire logic             ref_clk_i,
   input  wire logic             srst_i,
   input  wire logic             ctrl_wr_i,
   input  wire logic [7:0]       ctrl_wdata_i,
   input  wire logic             tube_scan_go_i,
   input  wire logic             led_scan_go_i,
   input  wire logic [OUT_W-1:0] tube_data_i,
   input  wire logic [LED_W-1:0] led_data_i,
   output logic [OUT_W-1:0]      tube_out_o,
   output logic [LED_W-1:0]      led_out_o,
   output logic [4:0]            slot_index_o,
   output logic                  slot_start_o,
   output logic                  scan_active_o
);

   vfdtc_regs_s r;
   vfdtc_regs_s next_r;
   logic [SLOT_CNT_W-1:0] slot_last;

   // terminal count of one slot for a width selection
   function automatic logic [SLOT_CNT_W-1:0] slot_len_m1(
      input logic [1:0] sel
   );
      logic [SLOT_CNT_W:0] len;
      len = (SLOT_CNT_W+1)'(1) << (SLOT_LOG2_BASE + int'(sel));
      return SLOT_CNT_W'(len - (SLOT_CNT_W+1)'(1));
   endfunction

   assign slot_last = slot_len_m1(r.ctrl.slot_width_sel);

   // next state of the sequencer and register
   always_comb begin
      next_r            = r;
      next_r.slot_start = 1'b0;
      // byte write only, no readback path exists
      if (ctrl_wr_i) begin
         next_r.ctrl.output_invert_bit = ctrl_wdata_i[CTRL_INV_POS];
         next_r.ctrl.slot_width_sel    = ctrl_wdata_i[CTRL_WID_LSB +: 2];
         next_r.ctrl.slot_count        = ctrl_wdata_i[CTRL_CNT_LSB +: 5];
      end
      unique case (r.state)
         VFDTC_IDLE: begin
            if (tube_scan_go_i) begin
               next_r.state      = VFDTC_RUN;
               next_r.tick       = '0;
               next_r.slot       = '0;
               next_r.slot_start = 1'b1;
               next_r.active     = 1'b1;
            end
         end
         VFDTC_RUN, VFDTC_STOP: begin
            if (!tube_scan_go_i && r.state == VFDTC_RUN) begin
               next_r.state = VFDTC_STOP;
            end
            if (r.tick == slot_last) begin
               next_r.tick = '0;
               // stop takes effect only at a slot boundary
               if (r.state == VFDTC_STOP || !tube_scan_go_i) begin
                  next_r.state  = VFDTC_IDLE;
                  next_r.active = 1'b0;
               end else begin
                  next_r.slot_start = 1'b1;
                  if (r.slot >= r.ctrl.slot_count) begin
                     next_r.slot = '0;
                  end else begin
                     next_r.slot = r.slot + 5'h01;
                  end
               end
            end else begin
               next_r.tick = r.tick + SLOT_CNT_W'(1);
            end
         end
         default: begin
            next_r.state  = VFDTC_IDLE;
            next_r.active = 1'b0;
         end
      endcase
   end

   // single state register; fields written mid-scan are the user's hazard
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         r.ctrl       <= vfdtc_ctrl_s'(CTRL_RESET);
         r.state      <= VFDTC_IDLE;
         r.tick       <= '0;
         r.slot       <= '0;
         r.slot_start <= 1'b0;
         r.active     <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // output flops; tube blanked level follows the inversion too, led pins are never inverted
   // ram word is looked up by the registered slot, so pins trail it a cycle
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         tube_out_o <= '0;
         led_out_o  <= '0;
      end else begin
         tube_out_o <= (r.active ? tube_data_i : '0)
                       ^ {OUT_W{r.ctrl.output_invert_bit}};
         led_out_o  <= led_scan_go_i ? led_data_i : '0;
      end
   end

   assign slot_index_o  = r.slot;
   assign slot_start_o  = r.slot_start;
   assign scan_active_o = r.active;

endmodule
`default_nettype wire

// [src/vfdtc_pkg.sv]
package vfdtc_pkg;
   // register layout
   localparam int          CTRL_INV_POS   = 7;
   localparam int          CTRL_WID_LSB   = 5;
   localparam int          CTRL_CNT_LSB   = 0;
   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   // slot length is 2^(BASE + sel) machine clocks
   localparam int          SLOT_LOG2_BASE = 11;
   localparam int          SLOT_CNT_W     = 14;

   // configuration register fields
   typedef struct packed {
      logic       output_invert_bit;
      logic [1:0] slot_width_sel;
      logic [4:0] slot_count;
   } vfdtc_ctrl_s;

   typedef enum logic [1:0] {
      VFDTC_IDLE = 2'b00,
      VFDTC_RUN  = 2'b01,
      VFDTC_STOP = 2'b10
   } vfdtc_state_e;

   // whole state of the block except the output flops
   typedef struct packed {
      vfdtc_ctrl_s               ctrl;
      vfdtc_state_e              state;
      logic [SLOT_CNT_W-1:0]     tick;
      logic [4:0]                slot;
      logic                      slot_start;
      logic                      active;
   } vfdtc_regs_s;
endpackage

// [test/vfdtc_ram_model.sv]
`timescale 1ns/100ps
`default_nettype none
// one distinct word per slot so a wrong slot shows at the pins
module vfdtc_ram_model (input wire logic [4:0] slot_i,
   output logic [59:0] data_o);
   assign data_o = {12{slot_i}} ^ 60'hC3A59F017E6D2B4;
endmodule
`default_nettype wire

// [test/vfdtc_scan_timing_props.sv]
`timescale 1ns/100ps
`default_nettype none
module vfdtc_props (input wire logic ref_clk_i, srst_i, ctrl_wr_i,
   input wire logic tube_scan_go_i, led_scan_go_i, slot_start_o,
   input wire logic scan_active_o, input wire logic [7:0] ctrl_wdata_i,
   input wire logic [4:0] slot_index_o,
   input wire logic [59:0] tube_out_o, tube_data_i,
   input wire logic [16:0] led_data_i, led_out_o);
   logic [7:0] cfg;
   logic [14:0] cnt, len;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   // shadow config and cycle count within the slot
   always_ff @(posedge ref_clk_i) begin
      cfg <= srst_i ? 8'h00 : ctrl_wr_i ? ctrl_wdata_i : cfg;
      cnt <= scan_active_o ? (slot_start_o ? 15'h1 : cnt + 15'h1) : 15'h0;
   end
   assign len = 15'h1 << (11 + cfg[6:5]);
   sequence slot_end; slot_start_o && cnt != 15'h0; endsequence
   a_go_start: assert property (!scan_active_o && tube_scan_go_i |=>
      slot_start_o && slot_index_o == 5'h0) else $error("start");
   a_slot_len: assert property (slot_end |-> cnt == len)
      else $error("length");
   a_slot_wrap: assert property (slot_end |-> slot_index_o ==
      ($past(slot_index_o) == cfg[4:0] ? 5'h0 : $past(slot_index_o) + 5'h1))
      else $error("order");
   a_stop_end: assert property ($fell(scan_active_o) |->
      cnt == len) else $error("stop");
   a_tube_blank: assert property (!$past(scan_active_o) |->
      tube_out_o == {60{$past(cfg[7])}}) else $error("blank");
   a_tube_data: assert property ($past(scan_active_o) |->
      tube_out_o == ($past(tube_data_i) ^ {60{$past(cfg[7])}}))
      else $error("data");
   a_led_plain: assert property (led_out_o == ($past(led_scan_go_i) ?
      $past(led_data_i) : 17'h0)) else $error("led");
   a_reset_zero: assert property (disable iff (1'b0) srst_i |=>
      tube_out_o == 60'h0 && slot_index_o == 5'h0) else $error("reset");
endmodule
bind vfdtc_scan_timing vfdtc_props props_i (.*);
`default_nettype wire

// [test/test_vfdtc_scan_timing.sv]
`timescale 1ns/100ps
`default_nettype none
module test_vfdtc_scan_timing;
   logic ref_clk_i=0, srst_i=1, ctrl_wr_i=0, tube_scan_go_i=0, led_scan_go_i=0;
   logic slot_start_o, scan_active_o;
   logic [7:0] ctrl_wdata_i=0;
   logic [4:0] slot_index_o, q[$];
   logic [59:0] tube_data_i, tube_out_o;
   logic [16:0] led_data_i=0, led_out_o;
   logic [31:0] r=88753;
   int n_fail=0, tests_run=0;
   vfdtc_scan_timing vfdtc_scan_timing_i (.*);
   vfdtc_ram_model vfdtc_ram_model_i (.slot_i(slot_index_o), .data_o(tube_data_i));
   initial forever #25 ref_clk_i = ~ref_clk_i;
   function logic [31:0] xs;
      r ^= r << 13;
      r ^= r >> 17;
      return r ^ (r << 5);
   endfunction
   task chk(input logic [59:0] s, e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %0t mismatch", $time);
      end
   endtask
   task results;
      if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // each slot start is matched with the oldest note
   always @(posedge ref_clk_i) if (slot_start_o === 1'b1)
      chk(slot_index_o, q.size() ? q.pop_front() : 5'h1F);
   initial #4000000 begin n_fail++; results(); end
   initial begin
      repeat (8) @(posedge ref_clk_i);
      #5 srst_i = 0;
      chk(tube_out_o, 0);
      // one pass per slot width; long widths run one slot to keep it short
      for (int k = 0; k < 4; k++) begin
         r = xs();
         if (k > 1) r[1:0] = 2'h0;
         @(posedge ref_clk_i);
         #5 {ctrl_wr_i, ctrl_wdata_i} = {1'b1, k[0], k[1:0], 3'h0, r[1:0]};
         @(posedge ref_clk_i);
         #5 {ctrl_wr_i, led_scan_go_i, tube_scan_go_i} = 3'b011;
         led_data_i = r[24:8];
         for (int i = 0; i <= r[1:0] + (k < 2); i++)
            q.push_back(5'(i > r[1:0] ? 0 : i));
         for (int c = 0; c < 20000 && q.size() > 0; c++) @(posedge ref_clk_i);
         #5 tube_scan_go_i = 0;
         chk(led_out_o, led_data_i);
         for (int c = 0; c < 17000 && scan_active_o !== 1'b0; c++)
            @(posedge ref_clk_i);
         #5 led_scan_go_i = 0;
         chk(tube_out_o, {60{k[0]}});
      end
      results();
   end
endmodule
`default_nettype wire
